// ==== core/tpw_pkg.sv ====
// Constants for the 16-bit PWM / free-running timer channel.
// Assumes an APB master on one clock; count clock equals MCLK.
package tpw_pkg;
  localparam logic [7:0]  OFS_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_OPT   = 8'h04;
  localparam logic [7:0]  OFS_EDGE  = 8'h08;
  localparam logic [7:0]  OFS_CMP0  = 8'h0C;
  localparam logic [7:0]  OFS_CMP1  = 8'h10;
  localparam logic [7:0]  OFS_COUNT = 8'h14;
  localparam int          CTRL_RUN_BIT  = 0;
  localparam int          CTRL_MODE_LSB = 1;
  localparam int          OPT_OVF_BIT   = 0;
  localparam int          OPT_CCS0_BIT  = 4;
  localparam int          OPT_CCS1_BIT  = 5;
  localparam logic [2:0]  MODE_PWM  = 3'h4;
  localparam logic [2:0]  MODE_FREE = 3'h5;
  localparam logic [15:0] CNT_IDLE  = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [1:0]  EDGE_NONE = 2'h0;
  localparam logic [1:0]  EDGE_RISE = 2'h1;
  localparam logic [1:0]  EDGE_FALL = 2'h2;
  localparam logic [1:0]  EDGE_BOTH = 2'h3;
endpackage

// ==== core/tpw_edge.sv ====
// Valid-edge detector for one capture input.
// Assumes the input is already synchronous to MCLK.
`timescale 1ns/1ps
module tpw_edge
  import tpw_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       pin,
  input  wire logic [1:0] sel,
  output logic            edge_seen
);
  logic prev_q;
  logic prev_d;

  always_comb begin
    prev_d = pin;
    case (sel)
      EDGE_RISE: edge_seen = pin & ~prev_q;
      EDGE_FALL: edge_seen = ~pin & prev_q;
      EDGE_BOTH: edge_seen = pin ^ prev_q;
      default:   edge_seen = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end
endmodule // tpw_edge

// ==== core/tpw_ccr.sv ====
// One compare/capture register with its shadow buffer.
// Assumes write and capture strobes are single-cycle; load may be held high for many cycles.
`timescale 1ns/1ps
module tpw_ccr
  import tpw_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         wr,
  input  wire logic [W-1:0] wdata,
  input  wire logic         cap,
  input  wire logic [W-1:0] cnt,
  input  wire logic         load,
  output logic      [W-1:0] ccr_q,
  output logic      [W-1:0] shadow_q
);
  logic [W-1:0] ccr_d;
  logic [W-1:0] shadow_d;

  always_comb begin
    ccr_d    = ccr_q;
    shadow_d = shadow_q;
    // A capture beats a software write in the same cycle
    if (cap) begin
      ccr_d = cnt;
    end else if (wr) begin
      ccr_d = wdata;
    end
    if (load) begin
      shadow_d = ccr_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ccr_q    <= CMP_RESET;
      shadow_q <= CMP_RESET;
    end else begin
      ccr_q    <= ccr_d;
      shadow_q <= shadow_d;
    end
  end
endmodule // tpw_ccr

// ==== core/tpw_timer.sv ====
// Timer channel top: APB registers, counter, PWM and free-running modes.
// Assumes APB master on MCLK and capture pins synchronous to MCLK.
`timescale 1ns/1ps
module tpw_timer
  import tpw_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [1:0]  CAPTURE_INPUT_M,
  output logic             TIMER_OUT_ZERO,
  output logic             TIMER_OUT_ONE,
  output logic             COMPARE0_IRQ,
  output logic             COMPARE1_IRQ,
  output logic             OVERFLOW_IRQ
);
  logic        run_q, run_d;
  logic [2:0]  mode_q, mode_d;
  logic        ovf_flag_q, ovf_flag_d;
  logic [1:0]  ccs_q, ccs_d;
  logic [3:0]  edge_sel_q, edge_sel_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ready_q, ready_d;
  logic        err_q, err_d;
  logic [15:0] cnt_q, cnt_d;
  logic        started_q, started_d;
  logic        pend_q, pend_d;
  logic [1:0]  out_q, out_d;
  logic [1:0]  cc_irq_q, cc_irq_d;
  logic        ovf_irq_q, ovf_irq_d;
  logic        setup, access, wr_en, mapped;
  logic        pwm, free, active, wrap, xfer, ovf_evt, load;
  logic [1:0]  cmp_wr, cap_edge, cap_hit, cap_sel;
  logic [15:0] ccr [2];
  logic [15:0] sh [2];
  logic [15:0] sh1_nx;

  assign setup  = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE & ready_q;
  assign wr_en  = access & PWRITE & ~err_q;
  assign mapped = (PADDR == OFS_CTRL) || (PADDR == OFS_OPT) || (PADDR == OFS_EDGE)
               || (PADDR == OFS_CMP0) || (PADDR == OFS_CMP1) || (PADDR == OFS_COUNT);
  assign cmp_wr[0] = wr_en & (PADDR == OFS_CMP0);
  assign cmp_wr[1] = wr_en & (PADDR == OFS_CMP1);

  assign pwm    = (mode_q == MODE_PWM);
  assign free   = (mode_q == MODE_FREE);
  assign active = run_q & (pwm | free);
  // Capture selects mean nothing in PWM mode
  assign cap_sel = free ? ccs_q : 2'b00;
  assign wrap    = active & started_q & pwm & (cnt_q == sh[0]);
  assign xfer    = wrap & pend_q;
  // While stopped the shadows track the registers so a start uses fresh values
  assign load    = xfer | ~active;
  assign sh1_nx  = xfer ? ccr[1] : sh[1];
  assign ovf_evt = active & started_q & free & (cnt_q == CNT_IDLE);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      tpw_edge u_edge (
        .clk       (MCLK),
        .rst_n     (RESETN),
        .pin       (CAPTURE_INPUT_M[g]),
        .sel       (edge_sel_q[2*g +: 2]),
        .edge_seen (cap_edge[g])
      );
      assign cap_hit[g] = active & started_q & cap_sel[g] & cap_edge[g];
      tpw_ccr #(.W(16)) u_ccr (
        .clk      (MCLK),
        .rst_n    (RESETN),
        .wr       (cmp_wr[g]),
        .wdata    (PWDATA[15:0]),
        .cap      (cap_hit[g]),
        .cnt      (cnt_q),
        .load     (load),
        .ccr_q    (ccr[g]),
        .shadow_q (sh[g])
      );
    end
  endgenerate

  // Register file and APB answer, one setup and one access cycle
  always_comb begin
    run_d      = run_q;
    mode_d     = mode_q;
    ccs_d      = ccs_q;
    edge_sel_d = edge_sel_q;
    ready_d    = setup;
    err_d      = setup & ~mapped;
    rdata_d    = rdata_q;
    if (setup) begin
      case (PADDR)
        OFS_CTRL:  rdata_d = {28'h0000000, mode_q, run_q};
        OFS_OPT:   rdata_d = {26'h0000000, ccs_q, 3'h0, ovf_flag_q};
        OFS_EDGE:  rdata_d = {28'h0000000, edge_sel_q};
        OFS_CMP0:  rdata_d = {16'h0000, ccr[0]};
        OFS_CMP1:  rdata_d = {16'h0000, ccr[1]};
        OFS_COUNT: rdata_d = {16'h0000, cnt_q};
        default:   rdata_d = 32'h00000000;
      endcase
    end
    if (wr_en && PADDR == OFS_CTRL) begin
      run_d  = PWDATA[CTRL_RUN_BIT];
      mode_d = PWDATA[CTRL_MODE_LSB +: 3];
    end
    if (wr_en && PADDR == OFS_OPT) begin
      ccs_d = {PWDATA[OPT_CCS1_BIT], PWDATA[OPT_CCS0_BIT]};
    end
    if (wr_en && PADDR == OFS_EDGE) begin
      edge_sel_d = PWDATA[3:0];
    end
  end

  // Flag clears only by a write with bit 0 low; an overflow in that cycle wins
  always_comb begin
    ovf_flag_d = ovf_flag_q;
    if (wr_en && PADDR == OFS_OPT && !PWDATA[OPT_OVF_BIT]) begin
      ovf_flag_d = 1'b0;
    end
    if (ovf_evt) begin
      ovf_flag_d = 1'b1;
    end
  end

  // Transfer arms only on a compare-1 write; a write in the transfer cycle re-arms
  always_comb begin
    pend_d = pend_q & ~xfer;
    if (cmp_wr[1]) begin
      pend_d = 1'b1;
    end
  end

  // Counter, outputs and interrupt pulses
  always_comb begin
    cnt_d     = cnt_q;
    started_d = started_q;
    out_d     = out_q;
    cc_irq_d  = 2'b00;
    ovf_irq_d = 1'b0;
    if (!active) begin
      cnt_d     = CNT_IDLE;
      started_d = 1'b0;
      out_d     = 2'b00;
    end else if (!started_q) begin
      cnt_d     = CNT_ZERO;
      started_d = 1'b1;
      if (pwm) begin
        out_d[0] = ~out_q[0];
        out_d[1] = (CNT_ZERO < sh1_nx);
        cc_irq_d[1] = (sh1_nx == CNT_ZERO);
      end else begin
        out_d = ~out_q;
      end
    end else if (pwm) begin
      cnt_d = wrap ? CNT_ZERO : 16'(cnt_q + 16'h0001);
      // Zero and compare1 > compare0 both fall out of this compare
      out_d[1]    = (cnt_d < sh1_nx);
      out_d[0]    = wrap ? ~out_q[0] : out_q[0];
      cc_irq_d[0] = wrap;
      cc_irq_d[1] = (cnt_d == sh1_nx);
    end else begin
      cnt_d     = 16'(cnt_q + 16'h0001);
      ovf_irq_d = ovf_evt;
      for (int m = 0; m < 2; m++) begin
        // Compares use the live register, not a shadow
        if (!ccs_q[m] && cnt_q == ccr[m]) begin
          cc_irq_d[m] = 1'b1;
          out_d[m]    = ~out_q[m];
        end
        if (cap_hit[m]) begin
          cc_irq_d[m] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      run_q      <= 1'b0;
      mode_q     <= 3'h0;
      ovf_flag_q <= 1'b0;
      ccs_q      <= 2'b00;
      edge_sel_q <= 4'h0;
      rdata_q    <= 32'h00000000;
      ready_q    <= 1'b0;
      err_q      <= 1'b0;
      cnt_q      <= CNT_IDLE;
      started_q  <= 1'b0;
      pend_q     <= 1'b0;
      out_q      <= 2'b00;
      cc_irq_q   <= 2'b00;
      ovf_irq_q  <= 1'b0;
    end else begin
      run_q      <= run_d;
      mode_q     <= mode_d;
      ovf_flag_q <= ovf_flag_d;
      ccs_q      <= ccs_d;
      edge_sel_q <= edge_sel_d;
      rdata_q    <= rdata_d;
      ready_q    <= ready_d;
      err_q      <= err_d;
      cnt_q      <= cnt_d;
      started_q  <= started_d;
      pend_q     <= pend_d;
      out_q      <= out_d;
      cc_irq_q   <= cc_irq_d;
      ovf_irq_q  <= ovf_irq_d;
    end
  end

  assign PRDATA         = rdata_q;
  assign PREADY         = ready_q;
  assign PSLVERR        = err_q;
  assign TIMER_OUT_ZERO = out_q[0];
  assign TIMER_OUT_ONE  = out_q[1];
  assign COMPARE0_IRQ   = cc_irq_q[0];
  assign COMPARE1_IRQ   = cc_irq_q[1];
  assign OVERFLOW_IRQ   = ovf_irq_q;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  logic pwm_on;
  assign pwm_on = run_q & pwm & started_q;

  property p_idle;
    !active |=> cnt_q == 16'hFFFF && !COMPARE0_IRQ && !OVERFLOW_IRQ && !TIMER_OUT_ONE;
  endproperty
  a_idle: assert property (p_idle) else $error("stopped counter not idle");

  property p_start;
    $rose(run_q) && pwm |=> cnt_q == 16'h0000 ##1 cnt_q == 16'h0001 || $past(wrap);
  endproperty
  a_start: assert property (p_start) else $error("PWM start did not wrap to zero");

  property p_wrap;
    wrap && active |=> cnt_q == 16'h0000 && COMPARE0_IRQ
      && TIMER_OUT_ZERO != $past(TIMER_OUT_ZERO);
  endproperty
  a_wrap: assert property (p_wrap) else $error("period end mishandled");

  property p_duty;
    pwm_on |-> TIMER_OUT_ONE == (cnt_q < sh[1]);
  endproperty
  a_duty: assert property (p_duty) else $error("PWM level wrong");

  property p_shadow;
    pwm_on && $past(pwm_on) && ($changed(sh[0]) || $changed(sh[1])) |-> cnt_q == 16'h0000
      && !pend_q || $past(cmp_wr[1]);
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow loaded mid-period");

  property p_noarm;
    wrap && !pend_q |=> $stable(sh[0]) && $stable(sh[1]);
  endproperty
  a_noarm: assert property (p_noarm) else $error("shadow moved without arming");

  property p_cc1;
    pwm_on && COMPARE1_IRQ |-> cnt_q == sh[1] && !TIMER_OUT_ONE;
  endproperty
  a_cc1: assert property (p_cc1) else $error("compare1 pulse misaligned");

  property p_ovf;
    ovf_evt |=> OVERFLOW_IRQ && ovf_flag_q && cnt_q == 16'h0000;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not raised");

  property p_flag;
    ovf_flag_q && !(wr_en && PADDR == OFS_OPT) |=> ovf_flag_q;
  endproperty
  a_flag: assert property (p_flag) else $error("overflow flag lost");

  property p_fcmp;
    active && started_q && free && !ccs_q[0] && cnt_q == ccr[0]
      |=> COMPARE0_IRQ && TIMER_OUT_ZERO != $past(TIMER_OUT_ZERO);
  endproperty
  a_fcmp: assert property (p_fcmp) else $error("free-run compare missed");

  property p_cap;
    cap_hit[1] |=> COMPARE1_IRQ && ccr[1] == $past(cnt_q);
  endproperty
  a_cap: assert property (p_cap) else $error("capture not stored");

  property p_rdcnt;
    setup && PADDR == OFS_COUNT |=> PRDATA == {16'h0000, $past(cnt_q)} && PREADY;
  endproperty
  a_rdcnt: assert property (p_rdcnt) else $error("count read-back wrong");

  c_xfer: cover property (xfer);
  c_ovf:  cover property (ovf_evt ##1 (wr_en && PADDR == OFS_OPT));
  c_cap:  cover property (cap_hit[0]);
endmodule // tpw_timer

// ==== testbench/tpw_pins.sv ====
// Far-side pin model: drives the two capture inputs of the timer channel.
// Assumes one-cycle fire strobes from the bench, synchronous to the clock.
`timescale 1ns/1ps
module tpw_pins (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] fire,
  output logic      [1:0] pin
);
  logic [1:0] len_q [2];
  logic [1:0] len_d [2];
  // Pulse held 3 clocks so rise, fall and both selects all see an edge
  always_comb begin
    for (int m = 0; m < 2; m++) begin
      len_d[m] = fire[m] ? 2'h3 : (len_q[m] != 2'h0) ? len_q[m] - 2'h1 : 2'h0;
      pin[m]   = (len_q[m] != 2'h0);
    end
  end
  always_ff @(posedge clk) begin
    for (int m = 0; m < 2; m++) begin
      len_q[m] <= rst_n ? len_d[m] : 2'h0;
    end
  end
endmodule // tpw_pins

// ==== testbench/test_timer_pwm_and_freerun_modes.sv ====
// Self-checking bench for the PWM / free-running timer channel.
// Assumes zero-wait APB slave and the pin model on the capture inputs.
`timescale 1ns/1ps
module test_timer_pwm_and_freerun_modes;
  import tpw_pkg::*;
  logic        MCLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, v, a;
  logic [1:0]  CAPTURE_INPUT_M, fire;
  logic        TIMER_OUT_ZERO, TIMER_OUT_ONE, COMPARE0_IRQ, COMPARE1_IRQ, OVERFLOW_IRQ;
  logic [33:0] rd_q [$];
  logic [47:0] pw_q [$];
  logic [15:0] per, hi, n1, c1;
  logic        o0, pwm_on;
  int          num_errors, total_checks;

  tpw_timer dut_u (.MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CAPTURE_INPUT_M(CAPTURE_INPUT_M), .TIMER_OUT_ZERO(TIMER_OUT_ZERO),
    .TIMER_OUT_ONE(TIMER_OUT_ONE), .COMPARE0_IRQ(COMPARE0_IRQ),
    .COMPARE1_IRQ(COMPARE1_IRQ), .OVERFLOW_IRQ(OVERFLOW_IRQ));
  tpw_pins pins_u (.clk(MCLK), .rst_n(RESETN), .fire(fire), .pin(CAPTURE_INPUT_M));

  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Request held from setup until PREADY is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge MCLK);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= ad; PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    r = PRDATA;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic care, input logic [32:0] e,
                    output logic [31:0] r);
    rd_q.push_back({care, e});
    apb(1'b0, ad, 32'h0, r);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, ad, d, r);
  endtask

  task automatic wait_ev(input int w, input int lim);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge MCLK);
      ok = (w == 0) ? COMPARE0_IRQ : (w == 1) ? COMPARE1_IRQ : OVERFLOW_IRQ;
    end
    chk(ok, 1'b1);
  endtask

  task automatic settle(input int n);
    repeat (n) wait_ev(0, 100);
  endtask

  // Queue pushed off the edge so a window never starts half counted
  task automatic expect_pw(input logic [15:0] p, input logic [15:0] h, input logic [15:0] k);
    @(negedge MCLK);
    repeat (2) pw_q.push_back({p, h, k});
    wait (pw_q.size() == 0);
  endtask

  task automatic pulse(input logic [1:0] f);
    fire <= f;
    @(posedge MCLK);
    fire <= 2'h0;
  endtask

  always @(posedge MCLK) begin
    logic [33:0] re;
    logic [47:0] pe;
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && rd_q.size() > 0) begin
      re = rd_q.pop_front();
      if (re[33]) chk({PSLVERR, PRDATA}, re[32:0]);
    end
    if (pwm_on && COMPARE1_IRQ === 1'b1) chk(TIMER_OUT_ONE, 1'b0);
    per = per + 16'h1;
    hi = hi + {15'h0, TIMER_OUT_ONE};
    n1 = n1 + {15'h0, COMPARE1_IRQ};
    if (COMPARE0_IRQ === 1'b1) begin
      if (pw_q.size() > 0) begin
        pe = pw_q.pop_front();
        chk({per, hi, n1}, pe);
        // Logical not keeps the expected toggle one bit wide in the wide argument
        chk(TIMER_OUT_ZERO, !o0);
      end
      o0 = TIMER_OUT_ZERO;
      per = 16'h0; hi = 16'h0; n1 = 16'h0;
    end
  end

  initial begin
    repeat (80000) @(posedge MCLK);
    num_errors++;
    final_report();
  end

  initial begin
    RESETN = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 8'h0;
    PWDATA = 32'h0; fire = 2'h0; pwm_on = 1'b0; num_errors = 0; total_checks = 0;
    per = 16'h0; hi = 16'h0; n1 = 16'h0;
    void'($urandom(32'h91A8F493));
    repeat (8) @(posedge MCLK);
    RESETN <= 1'b1;
    rd(OFS_CTRL, 1'b1, 33'h0, v);
    rd(OFS_COUNT, 1'b1, {17'h0, CNT_IDLE}, v);
    rd(8'h18, 1'b1, {1'b1, 32'h0}, v);
    wr(OFS_CMP0, 32'h9);
    wr(OFS_CMP1, 32'h3);
    pwm_on = 1'b1;
    wr(OFS_CTRL, {28'h0, MODE_PWM, 1'b1});
    settle(1);
    expect_pw(16'hA, 16'h3, 16'h1);
    wr(OFS_CMP0, 32'h13);
    settle(2);
    expect_pw(16'hA, 16'h3, 16'h1);
    wr(OFS_CMP1, 32'h3);
    settle(2);
    expect_pw(16'h14, 16'h3, 16'h1);
    c1 = 16'($urandom_range(19, 1));
    wr(OFS_CMP1, {16'h0, c1});
    settle(2);
    expect_pw(16'h14, c1, 16'h1);
    wr(OFS_CMP1, 32'h0);
    settle(2);
    expect_pw(16'h14, 16'h0, 16'h1);
    wr(OFS_OPT, 32'h30);
    wr(OFS_EDGE, 32'hF);
    wr(OFS_CMP1, 32'h14);
    pulse(2'h3);
    settle(2);
    expect_pw(16'h14, 16'h14, 16'h0);
    rd(OFS_CMP0, 1'b1, 33'h13, v);
    pwm_on = 1'b0;
    wr(OFS_CTRL, 32'h0);
    repeat (3) @(posedge MCLK);
    chk({TIMER_OUT_ZERO, TIMER_OUT_ONE, COMPARE0_IRQ, COMPARE1_IRQ, OVERFLOW_IRQ}, 5'h0);
    rd(OFS_COUNT, 1'b1, {17'h0, CNT_IDLE}, v);
    wr(OFS_OPT, 32'h20);
    wr(OFS_CMP0, 32'h5);
    wr(OFS_CTRL, {28'h0, MODE_FREE, 1'b1});
    wait_ev(0, 20);
    chk({TIMER_OUT_ZERO, TIMER_OUT_ONE}, 2'h1);
    rd(OFS_COUNT, 1'b0, 33'h0, v);
    wr(OFS_CMP0, {16'h0, v[15:0] + 16'h28});
    wait_ev(0, 60);
    wr(OFS_OPT, 32'h30);
    wr(OFS_EDGE, 32'h5);
    pulse(2'h1);
    repeat (19) @(posedge MCLK);
    pulse(2'h2);
    wait_ev(1, 20);
    rd(OFS_CMP0, 1'b0, 33'h0, a);
    rd(OFS_CMP1, 1'b0, 33'h0, v);
    // Difference kept to 16 bits so a counter wrap cannot widen it
    chk(16'(v[15:0] - a[15:0]), 16'h14);
    wait_ev(2, 70000);
    rd(OFS_OPT, 1'b1, 33'h31, v);
    wr(OFS_OPT, 32'h30);
    rd(OFS_OPT, 1'b1, 33'h30, v);
    final_report();
  end
endmodule // test_timer_pwm_and_freerun_modes
